// ---- include/acq_cfg.svh ----
// Constants and contract for the gated acquisition block
//Contract
// - Gate-level start command begins level acquisition
// - Edge start command begins gate-edge acquisition
// - Run time stored in microseconds
// - Off time microseconds, zero gives 120ns
// - Run and off times readable back
// - Timer start command begins timed acquisition
// - Stop ends acquisition and halts counting
// - Status register reports acquisition state
// - Read all: records zero to count-1
// - Extended reads cover all installed channels
// - Range read between start and end
// - K suffix multiplies extended range by thousand
// - Hex extended range marks high-speed mode
// - Subset read: channels and timer flag
// - Extended subset: two digits, flag 01
// - Name write clears flash storage address
// - Flash end in thousands stops acquisition
// - Flash end readable, 0 to 9999
// - Flash level start writes records out
// - Flash edge start writes records out
// - Flash timed start, stopped after power-up
// - RAM end address stops acquisition
// - Full or differential storage mode
`ifndef ACQ_CFG_SVH
`define ACQ_CFG_SVH
`define CLK_NS 40
`define US_NS 1000
`define OFF_MIN_NS 120
`define CYC_PER_US (`US_NS / `CLK_NS)
`define OFF_MIN_CYC ((`OFF_MIN_NS + `CLK_NS - 1) / `CLK_NS)
`define RUN_MIN_CYC 1
`define CH_BITS 512
`define REC_BITS 544
`define REC_W 17
`define DEPTH 16
`define IDX_W 4
`define CH_LAST 5'h0F
`define CH_BASIC 5'h07
`define TIME_W 5'h10
`define END_MAX 14'h270F
`define K_MULT 24'h0003E8
`define TIM_ON 2'h1
`define A_CMD 8'h00
`define A_STATUS 8'h04
`define A_RUN 8'h08
`define A_OFF 8'h0C
`define A_RAM_END 8'h10
`define A_FL_END 8'h14
`define A_MODE 8'h18
`define A_REC_NUM 8'h1C
`define A_RD_START 8'h20
`define A_RD_END 8'h24
`define A_RD_CFG 8'h28
`define A_RDATA 8'h2C
`define A_NAME_HI 4'h3
`define A_FL_ADDR 8'h40
`define C_LEVEL 4'h1
`define C_EDGE 4'h2
`define C_TIMED 4'h3
`define C_F_LEVEL 4'h4
`define C_F_EDGE 4'h5
`define C_F_TIMED 4'h6
`define C_STOP 4'h7
`define C_RD_ALL 4'h8
`define C_RD_RANGE 4'h9
`define C_RD_SUB 4'hA
`define F_HEX 0
`define F_EXT 1
`define F_K 2
`define F_TIM 5:4
`define F_TIM_D 4
`define F_FIRST 13:8
`define F_FIRST_D 11:8
`define F_LAST 21:16
`define F_LAST_D 19:16
`endif

// ---- include/acq_pkg.sv ----
// Types shared by the gated acquisition block
package acq_pkg;
	typedef enum logic [1:0] {
		ACQ_STOP  = 2'b00,
		ACQ_LEVEL = 2'b01,
		ACQ_EDGE  = 2'b10,
		ACQ_TIMED = 2'b11
	} acq_mode_t;
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_RUN  = 2'b01,
		PH_OFF  = 2'b10
	} phase_t;
	typedef logic [31:0] word_t;
endpackage

// ---- rtl/gate_timer.sv ----
// Internal run/off pacing timer
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
module gate_timer (
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Pacing control
	input  wire logic        run_en,
	input  wire logic [23:0] run_us,
	input  wire logic [23:0] off_us,
	// End of run interval
	output logic             sample_q
);
	import acq_pkg::*;
	phase_t      ph_q;
	logic [31:0] cnt_q;
	logic [31:0] run_lim;
	logic [31:0] off_lim;
	function automatic logic [31:0] lim(input logic [23:0] us, input logic [31:0] low);
		lim = (us == 24'h000000) ? low : ({8'h00, us} * 32'(`CYC_PER_US));
	endfunction
	assign run_lim = lim(run_us, 32'(`RUN_MIN_CYC));
	assign off_lim = lim(off_us, 32'(`OFF_MIN_CYC));
	// Phase sequencer
	always_ff @(posedge core_clk) begin
		if (!rst_n || !run_en) begin
			ph_q  <= PH_IDLE;
			cnt_q <= 32'h00000001;
		end else begin
			unique case (ph_q)
				PH_IDLE: ph_q <= PH_RUN;
				PH_RUN: begin
					cnt_q <= (cnt_q >= run_lim) ? 32'h00000001 : cnt_q + 32'h00000001;
					if (cnt_q >= run_lim) ph_q <= PH_OFF;
				end
				PH_OFF: begin
					cnt_q <= (cnt_q >= off_lim) ? 32'h00000001 : cnt_q + 32'h00000001;
					if (cnt_q >= off_lim) ph_q <= PH_RUN;
				end
				default: ph_q <= PH_IDLE;
			endcase
		end
	end
	// Record strobe
	always_ff @(posedge core_clk) begin
		if (!rst_n) sample_q <= 1'b0;
		else sample_q <= run_en & (ph_q == PH_RUN) & (cnt_q >= run_lim);
	end
	off_len_a: assert property (@(posedge core_clk) disable iff (!rst_n || !run_en)
		($rose(ph_q == PH_OFF) && off_us == 24'h000000) |-> (ph_q == PH_OFF) [*3] ##1 (ph_q == PH_RUN))
		else $error("Zero off time not three cycles");
endmodule // gate_timer
`default_nettype wire

// ---- rtl/record_store.sv ----
// Flip-flop record storage with differential option
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
module record_store (
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst_n,
	// Record write
	input  wire logic                 wr_en,
	input  wire logic [`IDX_W-1:0]    wr_idx,
	input  wire logic                 diff_mode,
	input  wire logic                 clr_prev,
	input  wire logic [`REC_BITS-1:0] wr_vals,
	// Word read
	input  wire logic [`IDX_W-1:0]    rd_idx,
	input  wire logic [4:0]           rd_word,
	output var  acq_pkg::word_t       rd_q
);
	import acq_pkg::*;
	word_t mem_q [`DEPTH][`REC_W];
	word_t prev_q [`REC_W];
	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			for (int w = 0; w < `REC_W; w++) begin
				mem_q[wr_idx][w] <= diff_mode ? wr_vals[w*32 +: 32] - prev_q[w] : wr_vals[w*32 +: 32];
			end
		end
	end
	// Previous absolute values
	always_ff @(posedge core_clk) begin
		for (int w = 0; w < `REC_W; w++) begin
			if (!rst_n || clr_prev) prev_q[w] <= '0;
			else if (wr_en) prev_q[w] <= wr_vals[w*32 +: 32];
		end
	end
	always_ff @(posedge core_clk) begin
		if (!rst_n) rd_q <= '0;
		else rd_q <= (rd_word <= `TIME_W) ? mem_q[rd_idx][rd_word] : '0;
	end
	diff_store_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		(wr_en && diff_mode) |=> mem_q[$past(wr_idx)][0] == $past(wr_vals[31:0]) - $past(prev_q[0]))
		else $error("Differential record word wrong");
endmodule // record_store
`default_nettype wire

// ---- rtl/gsync_acq.sv ----
// Gate and timer synchronous acquisition block with APB registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
module gsync_acq (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// APB slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire acq_pkg::word_t      pwdata,
	output var  acq_pkg::word_t      prdata,
	output logic                     pready,
	output logic                     pslverr,
	// Counter front end
	input  wire logic                gate_in,
	input  wire logic [`CH_BITS-1:0] ch_vals,
	input  wire acq_pkg::word_t      time_val,
	// Counting and flash side
	output logic                     count_halt,
	output logic                     flash_wr,
	output logic [23:0]              flash_addr
);
	import acq_pkg::*;

	// Acquisition state
	acq_mode_t   mode_q;
	logic        flash_q;
	logic        diff_q;
	logic [23:0] rec_num_q;
	logic [23:0] run_us_q;
	logic [23:0] off_us_q;
	logic [13:0] ram_end_q;
	logic [13:0] fend_q;
	word_t       name_q [4];
	logic        gate_q;
	// Readback setup and cursor
	logic [13:0] rd_start_q;
	logic [13:0] rd_end_q;
	logic [21:0] rd_cfg_q;
	logic        rd_busy_q;
	logic [23:0] rd_rec_q;
	logic [23:0] rd_stop_q;
	logic [4:0]  rd_w_q;
	logic [4:0]  rd_first_q;
	logic [4:0]  rd_last_q;
	logic        rd_tim_q;
	logic        rd_hex_q;
	logic        rd_hs_q;
	// Combinational
	logic        acc;
	logic        wacc;
	logic        cmd_wr;
	logic [3:0]  cmd;
	logic        start_cmd;
	logic        rd_cmd;
	logic        name_wr;
	logic        pop;
	logic        gate_rise;
	logic        gate_fall;
	logic        tmr_samp;
	logic        samp;
	logic        ram_hit;
	logic        fl_hit;
	logic        ext;
	logic [23:0] rs_d;
	logic [23:0] re_d;
	logic [4:0]  first_d;
	logic [4:0]  last_d;
	logic        tim_d;
	word_t       store_rd;
	word_t       rd_mux;
	logic        hit;

	function automatic logic [23:0] kilo(input logic [13:0] v);
		kilo = {10'h000, v} * `K_MULT;
	endfunction
	function automatic logic [4:0] clamp_ch(input logic [5:0] c);
		clamp_ch = (c > {1'b0, `CH_LAST}) ? `CH_LAST : c[4:0];
	endfunction
	function automatic logic [13:0] clamp_end(input logic [13:0] v);
		clamp_end = (v > `END_MAX) ? `END_MAX : v;
	endfunction

	// Bus strobes
	assign acc       = psel & penable & pready;
	assign wacc      = acc & pwrite;
	assign cmd       = pwdata[3:0];
	assign cmd_wr    = wacc & (paddr == `A_CMD);
	assign start_cmd = cmd_wr & (cmd >= `C_LEVEL) & (cmd <= `C_F_TIMED);
	assign rd_cmd    = cmd_wr & (cmd >= `C_RD_ALL) & (cmd <= `C_RD_SUB);
	assign name_wr   = wacc & (paddr[7:4] == `A_NAME_HI);
	assign pop       = acc & ~pwrite & (paddr == `A_RDATA) & rd_busy_q;

	// Sampling events
	assign gate_rise = gate_in & ~gate_q;
	assign gate_fall = ~gate_in & gate_q;
	assign samp = ((mode_q == ACQ_LEVEL) & gate_fall) | ((mode_q == ACQ_EDGE) & gate_rise)
		| ((mode_q == ACQ_TIMED) & tmr_samp);
	assign ram_hit = ~flash_q & (rec_num_q >= {10'h000, ram_end_q});
	assign fl_hit  = flash_q & (flash_addr >= kilo(fend_q));

	always_ff @(posedge core_clk) begin
		if (!rst_n) gate_q <= 1'b0;
		else gate_q <= gate_in;
	end

	// Acquisition mode
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			mode_q  <= ACQ_STOP;
			flash_q <= 1'b0;
		end else if (cmd_wr & (cmd == `C_STOP)) begin
			mode_q <= ACQ_STOP;
		end else if (start_cmd) begin
			flash_q <= (cmd >= `C_F_LEVEL);
			case (cmd)
				`C_LEVEL, `C_F_LEVEL: mode_q <= ACQ_LEVEL;
				`C_EDGE, `C_F_EDGE: mode_q <= ACQ_EDGE;
				default: mode_q <= ACQ_TIMED;
			endcase
		end else if (samp & (ram_hit | fl_hit)) begin
			mode_q <= ACQ_STOP;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) count_halt <= 1'b0;
		else count_halt <= cmd_wr & (cmd == `C_STOP);
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) rec_num_q <= '0;
		else if (samp) rec_num_q <= rec_num_q + 24'h000001;
	end

	// Flash write side
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flash_wr   <= 1'b0;
			flash_addr <= '0;
		end else begin
			flash_wr <= samp & flash_q;
			if (name_wr) flash_addr <= '0;
			else if (samp & flash_q) flash_addr <= flash_addr + 24'h000001;
		end
	end

	// Software settings
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			run_us_q  <= '0;
			off_us_q  <= '0;
			ram_end_q <= `END_MAX;
			fend_q    <= `END_MAX;
			diff_q    <= 1'b0;
		end else if (wacc) begin
			case (paddr)
				`A_RUN: run_us_q <= pwdata[23:0];
				`A_OFF: off_us_q <= pwdata[23:0];
				`A_RAM_END: ram_end_q <= clamp_end(pwdata[13:0]);
				`A_FL_END: fend_q <= clamp_end(pwdata[13:0]);
				`A_MODE: diff_q <= pwdata[0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) name_q[i] <= '0;
		end else if (name_wr) begin
			name_q[paddr[3:2]] <= pwdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_start_q <= '0;
			rd_end_q   <= '0;
			rd_cfg_q   <= '0;
		end else if (wacc) begin
			if (paddr == `A_RD_START) rd_start_q <= pwdata[13:0];
			if (paddr == `A_RD_END) rd_end_q <= pwdata[13:0];
			if (paddr == `A_RD_CFG) rd_cfg_q <= pwdata[21:0];
		end
	end

	// Readback range and channel selection
	assign ext = rd_cfg_q[`F_EXT];
	always_comb begin
		rs_d    = {10'h000, rd_start_q};
		re_d    = {10'h000, rd_end_q};
		first_d = 5'h00;
		last_d  = ext ? `CH_LAST : `CH_BASIC;
		tim_d   = 1'b1;
		if (ext & rd_cfg_q[`F_K]) begin
			rs_d = kilo(rd_start_q);
			re_d = kilo(rd_end_q);
		end
		if (cmd == `C_RD_ALL) begin
			rs_d = '0;
			re_d = rec_num_q - 24'h000001;
		end
		if (cmd == `C_RD_SUB) begin
			first_d = clamp_ch(ext ? rd_cfg_q[`F_FIRST] : {2'h0, rd_cfg_q[`F_FIRST_D]});
			last_d  = clamp_ch(ext ? rd_cfg_q[`F_LAST] : {2'h0, rd_cfg_q[`F_LAST_D]});
			tim_d   = ext ? (rd_cfg_q[`F_TIM] == `TIM_ON) : rd_cfg_q[`F_TIM_D];
		end
		if (first_d > last_d) last_d = first_d;
	end

	// Readback cursor, one word per data read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rd_busy_q  <= 1'b0;
			rd_rec_q   <= '0;
			rd_stop_q  <= '0;
			rd_w_q     <= '0;
			rd_first_q <= '0;
			rd_last_q  <= '0;
			rd_tim_q   <= 1'b0;
			rd_hex_q   <= 1'b0;
			rd_hs_q    <= 1'b0;
		end else if (rd_cmd) begin
			rd_busy_q  <= (rs_d <= re_d) & ~((cmd == `C_RD_ALL) & (rec_num_q == 24'h000000));
			rd_rec_q   <= rs_d;
			rd_stop_q  <= re_d;
			rd_w_q     <= first_d;
			rd_first_q <= first_d;
			rd_last_q  <= last_d;
			rd_tim_q   <= tim_d;
			rd_hex_q   <= rd_cfg_q[`F_HEX];
			rd_hs_q    <= rd_cfg_q[`F_HEX] & ext & (cmd == `C_RD_RANGE);
		end else if (pop) begin
			if ((rd_w_q == `TIME_W) || ((rd_w_q == rd_last_q) && !rd_tim_q)) begin
				rd_w_q    <= rd_first_q;
				rd_rec_q  <= rd_rec_q + 24'h000001;
				rd_busy_q <= (rd_rec_q != rd_stop_q);
			end else if (rd_w_q == rd_last_q) begin
				rd_w_q <= `TIME_W;
			end else begin
				rd_w_q <= rd_w_q + 5'h01;
			end
		end
	end

	// Register read decode
	always_comb begin
		hit    = 1'b1;
		rd_mux = '0;
		case (paddr)
			`A_CMD: rd_mux = '0;
			`A_STATUS: rd_mux = {25'h0000000, rd_hs_q, rd_hex_q, rd_busy_q, diff_q, flash_q, mode_q};
			`A_RUN: rd_mux = {8'h00, run_us_q};
			`A_OFF: rd_mux = {8'h00, off_us_q};
			`A_RAM_END: rd_mux = {18'h00000, ram_end_q};
			`A_FL_END: rd_mux = {18'h00000, fend_q};
			`A_MODE: rd_mux = {31'h00000000, diff_q};
			`A_REC_NUM: rd_mux = {8'h00, rec_num_q};
			`A_RD_START: rd_mux = {18'h00000, rd_start_q};
			`A_RD_END: rd_mux = {18'h00000, rd_end_q};
			`A_RD_CFG: rd_mux = {10'h000, rd_cfg_q};
			`A_RDATA: rd_mux = rd_busy_q ? store_rd : '0;
			`A_FL_ADDR: rd_mux = {8'h00, flash_addr};
			default: begin
				if (paddr[7:4] == `A_NAME_HI) rd_mux = name_q[paddr[3:2]];
				else hit = 1'b0;
			end
		endcase
	end

	// APB answer, one wait state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & penable & ~pready;
			if (psel & penable & ~pready) begin
				prdata  <= pwrite ? '0 : rd_mux;
				pslverr <= ~hit;
			end
		end
	end

	gate_timer u_timer (
		.core_clk (core_clk),
		.rst_n    (rst_n),
		.run_en   (mode_q == ACQ_TIMED),
		.run_us   (run_us_q),
		.off_us   (off_us_q),
		.sample_q (tmr_samp)
	);

	record_store u_store (
		.core_clk  (core_clk),
		.rst_n     (rst_n),
		.wr_en     (samp),
		.wr_idx    (rec_num_q[`IDX_W-1:0]),
		.diff_mode (diff_q),
		.clr_prev  (start_cmd),
		.wr_vals   ({time_val, ch_vals}),
		.rd_idx    (rd_rec_q[`IDX_W-1:0]),
		.rd_word   (rd_w_q),
		.rd_q      (store_rd)
	);

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	lvl_start_a: assert property (
		cmd_wr && cmd == `C_LEVEL |=> mode_q == ACQ_LEVEL && !flash_q)
		else $error("Level start not taken");
	edge_start_a: assert property (
		cmd_wr && cmd == `C_EDGE |=> mode_q == ACQ_EDGE && !flash_q)
		else $error("Edge start not taken");
	flash_start_a: assert property (
		cmd_wr && cmd == `C_F_TIMED |=> mode_q == ACQ_TIMED && flash_q)
		else $error("Flash timed start not taken");
	stop_cmd_a: assert property (
		cmd_wr && cmd == `C_STOP |=> mode_q == ACQ_STOP && count_halt ##1 !count_halt)
		else $error("Stop did not stop and halt");
	end_stop_a: assert property (
		samp && (ram_hit || fl_hit) && !start_cmd |=> mode_q == ACQ_STOP)
		else $error("End address did not stop");
	rec_step_a: assert property (
		samp |=> rec_num_q == $past(rec_num_q) + 24'h000001)
		else $error("Record number not advanced");
	name_clr_a: assert property (
		name_wr |=> flash_addr == 24'h000000 && !flash_wr)
		else $error("Name write did not clear address");
	read_all_a: assert property (
		cmd_wr && cmd == `C_RD_ALL && rec_num_q != 24'h000000
		|=> rd_busy_q && rd_rec_q == 24'h000000 && rd_stop_q == $past(rec_num_q) - 24'h000001)
		else $error("Read all range wrong");
	apb_wait_a: assert property (
		psel && penable && !pready |=> pready ##1 !pready)
		else $error("APB answer not one wait state");

	level_samp_c: cover property (samp && mode_q == ACQ_LEVEL);
	timed_samp_c: cover property (samp && mode_q == ACQ_TIMED && flash_q);
	read_done_c: cover property (pop ##1 !rd_busy_q);
endmodule // gsync_acq
`default_nettype wire

// ---- dv/frontend_model.sv ----
// Counter front-end model supplying channel and time values
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
module frontend_model (
	// Clock
	input  wire logic                core_clk,
	// Value selector from bench
	input  wire logic [15:0]         epoch,
	// Counter values
	output var  logic [`CH_BITS-1:0] ch_vals,
	output var  acq_pkg::word_t      time_val
);
	import acq_pkg::*;
	// Channel n: epoch above, n below
	always_ff @(posedge core_clk) begin
		for (int n = 0; n < 16; n++) begin
			ch_vals[n*32+:32] <= {epoch, 16'(n)};
		end
		time_val <= {16'hFFFF, epoch};
	end
endmodule // frontend_model
`default_nettype wire

// ---- dv/gsync_acq_bench.sv ----
// Self-checking bench for the gated acquisition block
`timescale 1ns/10ps
`default_nettype none
`include "acq_cfg.svh"
module gsync_acq_bench;
	import acq_pkg::*;
	logic                core_clk = 1'b0;
	logic                rst_n    = 1'b0;
	logic                psel     = 1'b0;
	logic                penable  = 1'b0;
	logic                pwrite   = 1'b0;
	logic [7:0]          paddr    = 8'h00;
	word_t               pwdata   = 32'h0;
	word_t               prdata;
	word_t               rdv;
	logic                pready;
	logic                pslverr;
	logic                err;
	logic                gate_in  = 1'b0;
	logic [15:0]         epoch    = 16'h0000;
	logic [`CH_BITS-1:0] ch_vals;
	word_t               time_val;
	logic                count_halt;
	logic                flash_wr;
	logic [23:0]         flash_addr;
	int                  fails    = 0;
	int                  compares = 0;
	int                  cyc      = 0;
	int                  halts    = 0;
	int                  fwrs     = 0;
	int                  t_last   = 0;
	int                  t_gap    = 0;
	int                  h0;
	int                  f0;

	always #20 core_clk = ~core_clk;

	gsync_acq dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.gate_in(gate_in), .ch_vals(ch_vals), .time_val(time_val), .count_halt(count_halt),
		.flash_wr(flash_wr), .flash_addr(flash_addr));
	frontend_model model_u (.core_clk(core_clk), .epoch(epoch), .ch_vals(ch_vals), .time_val(time_val));

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Pulse monitors and hang guard
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (count_halt === 1'b1) halts <= halts + 1;
		if (flash_wr === 1'b1) begin
			fwrs <= fwrs + 1;
			t_gap <= cyc - t_last;
			t_last <= cyc;
		end
		if (cyc == 20000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic check(input word_t seen, input word_t exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input word_t d, output word_t q);
		@(posedge core_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input word_t d);
		apb(1'b1, a, d, rdv);
	endtask

	task automatic rd(input logic [7:0] a, input word_t exp);
		apb(1'b0, a, 32'h0, rdv);
		check(rdv, exp);
	endtask

	task automatic rdcmd(input word_t cfg, input word_t s, input word_t e, input word_t cmd);
		wr(`A_RD_CFG, cfg);
		wr(`A_RD_START, s);
		wr(`A_RD_END, e);
		wr(`A_CMD, cmd);
	endtask

	// Words of records rs..re, channels f..l, then time
	task automatic read_words(input int f, input int l, input bit tim, input int rs, input int re);
		for (int r = rs; r <= re; r++) begin
			for (int c = f; c <= l; c++) rd(`A_RDATA, {16'(r + 1), 16'(c)});
			if (tim) rd(`A_RDATA, {16'hFFFF, 16'(r + 1)});
		end
		apb(1'b0, `A_STATUS, 32'h0, rdv);
		check(rdv & 32'h10, 32'h0);
	endtask

	task automatic pulse(input int e);
		@(posedge core_clk);
		epoch <= 16'(e);
		repeat (3) @(posedge core_clk);
		gate_in <= 1'b1;
		repeat (3) @(posedge core_clk);
		gate_in <= 1'b0;
		repeat (4) @(posedge core_clk);
	endtask

	initial begin
		repeat (3) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(`A_STATUS, 32'h0);
		rd(`A_MODE, 32'h0);
		rd(`A_RAM_END, 32'h270F);
		rd(`A_FL_END, 32'h270F);
		rd(`A_REC_NUM, 32'h0);
		wr(`A_RUN, 32'h04D2);
		rd(`A_RUN, 32'h04D2);
		rd(`A_OFF, 32'h0);
		wr(`A_OFF, 32'h0007);
		rd(`A_OFF, 32'h0007);
		wr(`A_FL_END, 32'h3000);
		rd(`A_FL_END, 32'h270F);
		apb(1'b0, 8'hFC, 32'h0, rdv);
		check({31'h0, err}, 32'h1);
		// Level gating up to the RAM end record
		wr(`A_RAM_END, 32'h2);
		wr(`A_CMD, 32'h1);
		rd(`A_STATUS, 32'h1);
		for (int e = 1; e <= 4; e++) pulse(e);
		rd(`A_STATUS, 32'h0);
		rd(`A_REC_NUM, 32'h3);
		wr(`A_RAM_END, 32'h270F);
		h0 = halts;
		wr(`A_CMD, 32'h7);
		repeat (3) @(posedge core_clk);
		check(32'(halts - h0), 32'h1);
		// Readback variants
		rdcmd(32'h1, 32'h0, 32'h0, `C_RD_ALL);
		rd(`A_STATUS, 32'h30);
		read_words(0, 7, 1, 0, 2);
		rdcmd(32'h2, 32'h0, 32'h0, `C_RD_ALL);
		read_words(0, 15, 1, 0, 2);
		rdcmd(32'h0004_0210, 32'h1, 32'h2, `C_RD_SUB);
		read_words(2, 4, 1, 1, 2);
		rdcmd(32'h000F_0E16, 32'h0, 32'h0, `C_RD_SUB);
		read_words(14, 15, 1, 0, 0);
		rdcmd(32'h0007_0702, 32'h2, 32'h2, `C_RD_SUB);
		read_words(7, 7, 0, 2, 2);
		rdcmd(32'h3, 32'h1, 32'h1, `C_RD_RANGE);
		rd(`A_STATUS, 32'h70);
		read_words(0, 15, 1, 1, 1);
		// Edge gating with differential storage
		wr(`A_MODE, 32'h1);
		wr(`A_CMD, 32'h2);
		rd(`A_STATUS, 32'h6A);
		pulse(5);
		pulse(7);
		wr(`A_CMD, 32'h7);
		rdcmd(32'h0001_0002, 32'h3, 32'h4, `C_RD_SUB);
		rd(`A_RDATA, 32'h0005_0000);
		rd(`A_RDATA, 32'h0005_0001);
		rd(`A_RDATA, 32'h0002_0000);
		rd(`A_RDATA, 32'h0002_0000);
		wr(`A_MODE, 32'h0);
		// Flash writing and its end address
		wr(`A_FL_END, 32'h0);
		wr({`A_NAME_HI, 4'h4}, 32'h4142_4344);
		rd(`A_FL_ADDR, 32'h0);
		rd({`A_NAME_HI, 4'h4}, 32'h4142_4344);
		wr(`A_CMD, 32'h4);
		rd(`A_STATUS, 32'h5);
		f0 = fwrs;
		pulse(8);
		pulse(9);
		check(32'(fwrs - f0), 32'h1);
		rd(`A_STATUS, 32'h4);
		rd(`A_FL_ADDR, 32'h1);
		wr(`A_CMD, 32'h5);
		rd(`A_STATUS, 32'h6);
		pulse(10);
		check(32'(fwrs - f0), 32'h2);
		rd(`A_STATUS, 32'h4);
		// Timed pacing, 1 us run, minimum off
		wr(`A_FL_END, 32'h270F);
		wr(`A_RUN, 32'h1);
		wr(`A_OFF, 32'h0);
		wr(`A_CMD, 32'h3);
		rd(`A_STATUS, 32'h3);
		wr(`A_CMD, 32'h6);
		rd(`A_STATUS, 32'h7);
		repeat (100) @(posedge core_clk);
		check(32'(t_gap), 32'h1C);
		wr(`A_CMD, 32'h7);
		repeat (2) @(posedge core_clk);
		f0 = fwrs;
		repeat (60) @(posedge core_clk);
		check(32'(fwrs - f0), 32'h0);
		wr({`A_NAME_HI, 4'h0}, 32'h5859_5A30);
		rd(`A_FL_ADDR, 32'h0);
		rd({`A_NAME_HI, 4'h0}, 32'h5859_5A30);
		// RAM run until the record number reaches 1001 at end record 1000, then K subset read of record 1000
		wr(`A_RAM_END, 32'h3E8);
		wr(`A_RUN, 32'h0);
		wr(`A_CMD, 32'h3);
		do begin
			apb(1'b0, `A_REC_NUM, 32'h0, rdv);
		end while (rdv < 32'h3E2);
		epoch <= 16'h000B;
		repeat (60) @(posedge core_clk);
		rd(`A_REC_NUM, 32'h3E9);
		rdcmd(32'h000F_0E16, 32'h1, 32'h1, `C_RD_SUB);
		rd(`A_RDATA, 32'h000B_000E);
		rd(`A_RDATA, 32'h000B_000F);
		rd(`A_RDATA, 32'hFFFF_000B);
		rd(`A_STATUS, 32'h0);
		print_verdict();
	end
endmodule // gsync_acq_bench
`default_nettype wire
